// ### rtl/sarseq_top.sv
// APB-reachable control and result logic of the 10-bit SAR converter
//
// Overview of operation
// - A 10-bit successive-approximation result lands in the result byte pair.
// - Exactly one of 16 analog inputs feeds the converter at a time.
// - Input above upper reference saturates: high byte FF, low byte 03.
// - Input below lower reference gives zero in both result bytes.
// - Four channel bits map codes 0 to 15 onto inputs 0 to 15.
// - While on, conversions of the chosen channel follow back to back.
// - Bit 5 on starts converting; off stops and aborts conversion.
// - Each completion sets read-only flag bit 7 and updates the result.
// - Reading the high byte or writing control/status clears the flag.
// - Results are not held; each completion overwrites both bytes.
// - Changing the channel aborts, clears the flag and restarts conversion.
// - Wait mode leaves the converter running as configured.
// - Halt disables the converter; software waits for stabilization afterwards.
// - High byte shows result bits 9..2 and is read-only.
// - Low byte shows result bits 1..0; bits 7..2 read zero.
`timescale 1ns/1ps
module sarseq_top
   import sarseq_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic halt_in,
   input wire logic comp_in,
   output logic [3:0] channel_select_out,
   output logic converter_enable_out,
   output logic sample_out,
   output logic [9:0] dac_code_out
);
   logic speed_q, speed_d;
   logic on_q, on_d;
   logic [3:0] chan_q, chan_d;
   logic eoc_q, eoc_d;
   logic [9:0] result_q, result_d;
   logic restart_q, restart_d;
   logic enable_q, enable_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic run;
   logic access;
   logic csr_write;
   logic high_read;
   logic eng_done;
   logic [9:0] eng_result;
   logic [7:0] csr_view;

   // Maps a bus address onto one of the three registers
   function automatic sarseq_sel_t reg_sel(input logic [11:0] addr);
      if (addr == SARSEQ_CSR_ADDR)
         reg_sel = SARSEQ_SEL_CSR;
      else if (addr == SARSEQ_HIGH_ADDR)
         reg_sel = SARSEQ_SEL_HIGH;
      else if (addr == SARSEQ_LOW_ADDR)
         reg_sel = SARSEQ_SEL_LOW;
      else
         reg_sel = SARSEQ_SEL_NONE;
   endfunction

   // Completing edge of an APB transfer and its register side effects
   assign access = psel_in && penable_in && pready_q;
   assign csr_write = access && pwrite_in && (reg_sel(paddr_in) == SARSEQ_SEL_CSR);
   assign high_read = access && !pwrite_in && (reg_sel(paddr_in) == SARSEQ_SEL_HIGH);
   // Halt stops the converter; wait mode has no input and no effect
   assign run = on_q && !halt_in;
   // Control/status byte as seen by software; bit 4 reads zero
   assign csr_view = {eoc_q, speed_q, on_q, 1'b0, chan_q};

   // Control, flag and result next values
   always_comb
   begin
      speed_d = speed_q;
      on_d = on_q;
      chan_d = chan_q;
      eoc_d = eoc_q;
      result_d = result_q;
      restart_d = 1'b0;
      enable_d = run;
      if (csr_write)
      begin
         speed_d = pwdata_in[SARSEQ_SPEED_BIT];
         on_d = pwdata_in[SARSEQ_ON_BIT];
         chan_d = pwdata_in[SARSEQ_CHAN_LSB +: SARSEQ_CHAN_W];
         restart_d = (pwdata_in[SARSEQ_CHAN_LSB +: SARSEQ_CHAN_W] != chan_q);
         eoc_d = 1'b0;
      end
      if (high_read)
         eoc_d = 1'b0;
      // A completion in the same cycle as a clear wins
      if (eng_done)
      begin
         eoc_d = 1'b1;
         result_d = eng_result;
      end
   end

   // Control, flag and result registers
   always_ff @(posedge core_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         speed_q <= SARSEQ_CSR_RESET[SARSEQ_SPEED_BIT];
         on_q <= SARSEQ_CSR_RESET[SARSEQ_ON_BIT];
         chan_q <= SARSEQ_CSR_RESET[SARSEQ_CHAN_LSB +: SARSEQ_CHAN_W];
         eoc_q <= SARSEQ_CSR_RESET[SARSEQ_EOC_BIT];
         result_q <= SARSEQ_RESULT_RESET;
         restart_q <= 1'b0;
         enable_q <= 1'b0;
      end
      else
      begin
         speed_q <= speed_d;
         on_q <= on_d;
         chan_q <= chan_d;
         eoc_q <= eoc_d;
         result_q <= result_d;
         restart_q <= restart_d;
         enable_q <= enable_d;
      end
   end

   // APB answer prepared in the setup cycle, presented in the access cycle
   always_comb
   begin
      pready_d = psel_in && !penable_in && !pready_q;
      pslverr_d = pslverr_q;
      prdata_d = prdata_q;
      if (psel_in && !penable_in)
      begin
         pslverr_d = (reg_sel(paddr_in) == SARSEQ_SEL_NONE);
         prdata_d = 32'h0000_0000;
         if (!pwrite_in)
         begin
            if (reg_sel(paddr_in) == SARSEQ_SEL_CSR)
               prdata_d = {24'h00_0000, csr_view};
            else if (reg_sel(paddr_in) == SARSEQ_SEL_HIGH)
               prdata_d = {24'h00_0000, result_q[9:2]};
            else if (reg_sel(paddr_in) == SARSEQ_SEL_LOW)
               prdata_d = {30'h0000_0000, result_q[1:0]};
         end
      end
      else if (access)
      begin
         pslverr_d = 1'b0;
         prdata_d = 32'h0000_0000;
      end
   end

   // APB answer registers
   always_ff @(posedge core_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else
      begin
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // Conversion engine
   sarseq_engine u_engine (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .run_in(run),
      .restart_in(restart_q),
      .fast_in(speed_q),
      .comp_in(comp_in),
      .sample_out(sample_out),
      .dac_code_out(dac_code_out),
      .done_out(eng_done),
      .result_out(eng_result)
   );

   assign prdata_out = prdata_q;
   assign pready_out = pready_q;
   assign pslverr_out = pslverr_q;
   assign channel_select_out = chan_q;
   assign converter_enable_out = enable_q;

   // Completion raises the flag on the next edge
   eoc_set_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      eng_done |=> (eoc_q && result_q == $past(eng_result)))
      else $error("completion did not set flag and result");
   // High-byte read without a completion clears the flag
   eoc_clear_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (high_read && !eng_done) |=> !eoc_q)
      else $error("high byte read left flag set");
   // Control write without a completion clears the flag
   csr_clear_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (csr_write && !eng_done) |=> !eoc_q)
      else $error("control write left flag set");
   // Channel change restarts with sampling two cycles later
   chan_restart_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (csr_write && pwdata_in[3:0] != chan_q && pwdata_in[SARSEQ_ON_BIT] && !halt_in)
      |=> ##1 sample_out)
      else $error("channel change did not restart sampling");
   // No completion while the converter is off or halted
   off_quiet_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (!on_q || halt_in) ##1 (!on_q || halt_in) |=> !eng_done)
      else $error("completion while converter disabled");
   // Halt drops the converter enable on the next edge
   halt_off_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      halt_in |=> !converter_enable_out)
      else $error("converter enabled during halt");
   // Low byte upper bits always read zero
   low_zero_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (psel_in && !penable_in && !pwrite_in && reg_sel(paddr_in) == SARSEQ_SEL_LOW)
      |=> (prdata_out[31:2] == 30'h0000_0000 && prdata_out[1:0] == $past(result_q[1:0])))
      else $error("low byte read wrong");
   // High byte shows result bits nine to two
   high_view_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (psel_in && !penable_in && !pwrite_in && reg_sel(paddr_in) == SARSEQ_SEL_HIGH)
      |=> (prdata_out == {24'h00_0000, $past(result_q[9:2])}))
      else $error("high byte read wrong");
   // Reserved bit never reads back as one
   rsvd_zero_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (psel_in && !penable_in && !pwrite_in && reg_sel(paddr_in) == SARSEQ_SEL_CSR)
      |=> !prdata_out[4])
      else $error("reserved bit read as one");
   // Continuous mode: another completion follows within one slow conversion
   cont_conv_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (eng_done && run && !csr_write) ##1 (run && !csr_write) [*8]
      |-> ##[1:60] (eng_done || !run || csr_write))
      else $error("continuous conversion stalled");
endmodule // sarseq_top

// ### rtl/sarseq_pkg.sv
// Shared constants and types for the successive-approximation sequencer
package sarseq_pkg;
   // Register indices as printed; byte address is four times the index
   localparam logic [9:0] SARSEQ_CSR_INDEX = 10'h070;
   localparam logic [9:0] SARSEQ_HIGH_INDEX = 10'h071;
   localparam logic [9:0] SARSEQ_LOW_INDEX = 10'h072;
   localparam logic [11:0] SARSEQ_CSR_ADDR = {SARSEQ_CSR_INDEX, 2'b00};
   localparam logic [11:0] SARSEQ_HIGH_ADDR = {SARSEQ_HIGH_INDEX, 2'b00};
   localparam logic [11:0] SARSEQ_LOW_ADDR = {SARSEQ_LOW_INDEX, 2'b00};
   // Control/status field positions
   localparam int SARSEQ_EOC_BIT = 7;
   localparam int SARSEQ_SPEED_BIT = 6;
   localparam int SARSEQ_ON_BIT = 5;
   localparam int SARSEQ_CHAN_LSB = 0;
   localparam int SARSEQ_CHAN_W = 4;
   localparam int SARSEQ_RES_W = 10;
   // Reset values
   localparam logic [7:0] SARSEQ_CSR_RESET = 8'h00;
   localparam logic [9:0] SARSEQ_RESULT_RESET = 10'h000;
   // Converter clock dividers and conversion shape
   localparam logic [1:0] SARSEQ_DIV_FAST_LAST = 2'h1;
   localparam logic [1:0] SARSEQ_DIV_SLOW_LAST = 2'h3;
   localparam logic [1:0] SARSEQ_SAMPLE_LAST = 2'h1;
   localparam logic [3:0] SARSEQ_MSB_INDEX = 4'h9;
   localparam logic [9:0] SARSEQ_FIRST_TRIAL = 10'h200;
   // Register select codes
   typedef enum logic [1:0] {SARSEQ_SEL_NONE, SARSEQ_SEL_CSR, SARSEQ_SEL_HIGH,
      SARSEQ_SEL_LOW} sarseq_sel_t;
   // Converter sequencing states
   typedef enum logic [1:0] {SARSEQ_IDLE, SARSEQ_SAMPLE, SARSEQ_CONVERT} sarseq_state_t;
endpackage

// ### rtl/sarseq_engine.sv
// Successive-approximation engine with converter clock divider
`timescale 1ns/1ps
module sarseq_engine
   import sarseq_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic run_in,
   input wire logic restart_in,
   input wire logic fast_in,
   input wire logic comp_in,
   output logic sample_out,
   output logic [9:0] dac_code_out,
   output logic done_out,
   output logic [9:0] result_out
);
   sarseq_state_t state_q, state_d;
   logic [1:0] div_q, div_d;
   logic [1:0] cnt_q, cnt_d;
   logic [3:0] bit_q, bit_d;
   logic [9:0] trial_q, trial_d;
   logic [9:0] result_q, result_d;
   logic done_q, done_d;
   logic sample_q, sample_d;
   logic tick;
   logic [9:0] decided;

   // Converter clock is CPU clock divided by 2 or 4
   assign tick = (div_q == (fast_in ? SARSEQ_DIV_FAST_LAST : SARSEQ_DIV_SLOW_LAST));
   // Current bit kept when the comparator says input is above the trial
   assign decided = comp_in ? trial_q : (trial_q & ~(10'h001 << bit_q));

   // Next-state logic of the sequencer
   always_comb
   begin
      state_d = state_q;
      div_d = tick ? 2'h0 : div_q + 2'h1;
      cnt_d = cnt_q;
      bit_d = bit_q;
      trial_d = trial_q;
      result_d = result_q;
      done_d = 1'b0;
      if (!run_in)
      begin
         state_d = SARSEQ_IDLE;
         div_d = 2'h0;
      end
      else if (restart_in)
      begin
         state_d = SARSEQ_SAMPLE;
         cnt_d = 2'h0;
         div_d = 2'h0;
      end
      else
      begin
         case (state_q)
            SARSEQ_IDLE:
            begin
               state_d = SARSEQ_SAMPLE;
               cnt_d = 2'h0;
            end
            SARSEQ_SAMPLE:
            begin
               if (tick)
               begin
                  cnt_d = cnt_q + 2'h1;
                  if (cnt_q == SARSEQ_SAMPLE_LAST)
                  begin
                     state_d = SARSEQ_CONVERT;
                     bit_d = SARSEQ_MSB_INDEX;
                     trial_d = SARSEQ_FIRST_TRIAL;
                  end
               end
            end
            SARSEQ_CONVERT:
            begin
               if (tick)
               begin
                  trial_d = decided;
                  if (bit_q == 4'h0)
                  begin
                     result_d = decided;
                     done_d = 1'b1;
                     state_d = SARSEQ_SAMPLE;
                     cnt_d = 2'h0;
                  end
                  else
                  begin
                     bit_d = bit_q - 4'h1;
                     trial_d = decided | (10'h001 << (bit_q - 4'h1));
                  end
               end
            end
            default: state_d = SARSEQ_IDLE;
         endcase
      end
      sample_d = (state_d == SARSEQ_SAMPLE);
   end

   // Sequencer registers
   always_ff @(posedge core_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         state_q <= SARSEQ_IDLE;
         div_q <= 2'h0;
         cnt_q <= 2'h0;
         bit_q <= 4'h0;
         trial_q <= SARSEQ_RESULT_RESET;
         result_q <= SARSEQ_RESULT_RESET;
         done_q <= 1'b0;
         sample_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         div_q <= div_d;
         cnt_q <= cnt_d;
         bit_q <= bit_d;
         trial_q <= trial_d;
         result_q <= result_d;
         done_q <= done_d;
         sample_q <= sample_d;
      end
   end

   assign sample_out = sample_q;
   assign dac_code_out = trial_q;
   assign done_out = done_q;
   assign result_out = result_q;

   // Input above the upper reference saturates at full scale
   sat_high_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (run_in && !restart_in && state_q == SARSEQ_CONVERT && tick && bit_q == 4'h0
      && comp_in && trial_q == 10'h3FF) |=> (done_q && result_q == 10'h3FF))
      else $error("full-scale input did not give 3FF");
   // Input below the lower reference gives zero
   sat_low_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (run_in && !restart_in && state_q == SARSEQ_CONVERT && tick && bit_q == 4'h0
      && !comp_in && trial_q == 10'h001) |=> (done_q && result_q == 10'h000))
      else $error("below-scale input did not give zero");
   // Fast converter clock ticks every second cycle
   div_fast_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (fast_in && run_in && tick) ##1 (fast_in && run_in && !restart_in) ##1 fast_in
      |-> tick)
      else $error("divide-by-two tick missing");
endmodule // sarseq_engine

// ### testbench/sar_adc_sequencer_tb_top.sv
// Self-checking bench for the SAR converter sequencer
`timescale 1ns/1ps
module sar_adc_sequencer_tb_top;
   import sarseq_pkg::*;
   logic core_clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0000_0000;
   logic halt_in = 1'b0;
   logic comp_in = 1'b0;
   logic [31:0] prdata_out;
   logic pready_out;
   logic pslverr_out;
   logic [3:0] channel_select_out;
   logic converter_enable_out;
   logic sample_out;
   logic [9:0] dac_code_out;
   int failures = 0;
   int checks_done = 0;
   int seed = 98564;
   int ain = 0;
   int e;
   int n1;
   int n2;
   logic [31:0] rd;
   logic err;

   sarseq_top i_sarseq_top (.core_clk_in(core_clk_in), .reset_in(reset_in),
      .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
      .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
      .pready_out(pready_out), .pslverr_out(pslverr_out), .halt_in(halt_in),
      .comp_in(comp_in), .channel_select_out(channel_select_out),
      .converter_enable_out(converter_enable_out), .sample_out(sample_out),
      .dac_code_out(dac_code_out));

   // Clock of 8 ns period
   always #4 core_clk_in = ~core_clk_in;

   // Comparator: analog level against the current trial code
   always @(posedge core_clk_in)
   begin
      comp_in <= (ain >= int'(dac_code_out));
   end

   // Expected result: saturating ideal conversion
   function automatic int model(input int a);
      if (a < 0)
         return 0;
      if (a > 1023)
         return 1023;
      return a;
   endfunction

   // Verdict and end of run
   task automatic finish_test();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Compare one value
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // One APB transfer, waits for pready at a bounded count
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge core_clk_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= wd;
      @(posedge core_clk_in);
      penable_in <= 1'b1;
      // Request held until pready is seen high at a rising edge
      do
      begin
         @(posedge core_clk_in);
         n++;
      end
      while (pready_out !== 1'b1 && n < 20);
      check({31'h0, pready_out}, 32'h1, "ready");
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask

   // Read and compare, no error expected
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      check(rd, exp, what);
      check({31'h0, err}, 32'h0, "no error");
   endtask

   // Control write, reserved bit kept zero
   task automatic wr_csr(input logic [7:0] v);
      apb(1'b1, SARSEQ_CSR_ADDR, {24'h0, v & 8'hEF});
   endtask

   // Poll the completion flag
   task automatic wait_flag();
      int n;
      n = 0;
      do
      begin
         apb(1'b0, SARSEQ_CSR_ADDR, 32'h0);
         n++;
      end
      while (rd[7] !== 1'b1 && n < 100);
      check({31'h0, rd[7]}, 32'h1, "flag set");
   endtask

   // Fresh conversion of one level on one channel
   task automatic conv(input int a, input logic [3:0] ch, input logic spd);
      wr_csr({1'b0, spd, 2'b00, ch});
      ain = a;
      repeat (8) @(posedge core_clk_in);
      wr_csr({1'b0, spd, 1'b1, 1'b0, ch});
      @(negedge core_clk_in);
      check({28'h0, channel_select_out}, {28'h0, ch}, "mux");
      rd_chk(SARSEQ_CSR_ADDR, {24'h0, 1'b0, spd, 2'b10, ch}, "csr");
      wait_flag();
      e = model(a);
      rd_chk(SARSEQ_LOW_ADDR, 32'(e & 3), "low");
      rd_chk(SARSEQ_HIGH_ADDR, 32'(e >> 2), "high");
      apb(1'b0, SARSEQ_CSR_ADDR, 32'h0);
      check({31'h0, rd[7]}, 32'h0, "flag cleared");
      wait_flag();
      rd_chk(SARSEQ_HIGH_ADDR, 32'(e >> 2), "repeat");
   endtask

   // Count clocks until sample_out reaches a level
   task automatic wait_level(input logic v, output int n);
      n = 0;
      while (sample_out !== v && n < 200)
      begin
         @(negedge core_clk_in);
         n++;
      end
   endtask

   // Watchdog
   initial
   begin
      #400000;
      failures++;
      finish_test();
   end

   // Main sequence
   initial
   begin
      repeat (4) @(posedge core_clk_in);
      reset_in <= 1'b0;
      rd_chk(SARSEQ_CSR_ADDR, 32'h0, "csr reset");
      rd_chk(SARSEQ_HIGH_ADDR, 32'h0, "high reset");
      rd_chk(SARSEQ_LOW_ADDR, 32'h0, "low reset");
      apb(1'b1, SARSEQ_HIGH_ADDR, 32'hFF);
      rd_chk(SARSEQ_HIGH_ADDR, 32'h0, "high read-only");
      apb(1'b1, 12'h1CC, 32'hFF);
      check({31'h0, err}, 32'h1, "unmapped write");
      apb(1'b0, 12'h1CC, 32'h0);
      check({31'h0, err}, 32'h1, "unmapped read");
      check(rd, 32'h0, "unmapped data");
      $display("test registers done");
      // Every channel, saturation and zero levels first
      for (int i = 0; i < 16; i++)
         conv(i == 0 ? -5 : i == 1 ? 0 : i == 2 ? 1023 : i == 3 ? 1500 :
            $random(seed) & 1023, i[3:0], i[0]);
      $display("test channels done");
      // Conversion period at both speeds
      for (int s = 0; s < 2; s++)
      begin
         wr_csr({1'b0, s[0], 1'b1, 1'b0, 4'h2});
         wait_level(1'b0, n1);
         wait_level(1'b1, n1);
         wait_level(1'b0, n1);
         wait_level(1'b1, n1);
         wait_level(1'b0, n1);
         wait_level(1'b1, n2);
         check(32'(n1 + n2), s == 1 ? 32'd24 : 32'd48, "period");
      end
      $display("test speed done");
      // Channel change mid-conversion
      wr_csr(8'h23);
      ain = 100;
      repeat (12) @(posedge core_clk_in);
      ain = 700;
      wr_csr(8'h29);
      rd_chk(SARSEQ_CSR_ADDR, 32'h29, "abort clears flag");
      wait_flag();
      rd_chk(SARSEQ_HIGH_ADDR, 32'(700 >> 2), "new channel");
      // Unread results are overwritten
      ain = 300;
      repeat (110) @(posedge core_clk_in);
      rd_chk(SARSEQ_LOW_ADDR, 32'(300 & 3), "overwrite low");
      rd_chk(SARSEQ_HIGH_ADDR, 32'(300 >> 2), "overwrite high");
      $display("test abort done");
      // Off stops everything
      wr_csr(8'h09);
      repeat (60) @(posedge core_clk_in);
      check({31'h0, converter_enable_out}, 32'h0, "off");
      rd_chk(SARSEQ_CSR_ADDR, 32'h09, "no flag while off");
      // Halt disables, wake resumes
      wr_csr(8'h61);
      ain = 512;
      @(posedge core_clk_in);
      halt_in <= 1'b1;
      repeat (60) @(posedge core_clk_in);
      check({31'h0, converter_enable_out}, 32'h0, "halted");
      rd_chk(SARSEQ_CSR_ADDR, 32'h61, "no flag in halt");
      halt_in <= 1'b0;
      wait_flag();
      rd_chk(SARSEQ_HIGH_ADDR, 32'(512 >> 2), "after wake");
      $display("test power done");
      finish_test();
   end
endmodule // sar_adc_sequencer_tb_top
